// ---- src/ddm_pkg.sv ----
// Functional notes
// - window enable is on while retained-power timer or second ignition is on
// - up and down outputs follow the switches only while that gate is on
// - with timer and second ignition both off, up and down stay off
// - auto up from idle/manual down/auto down: down off 40 ms then on
// - auto down from idle/manual up/auto up: up off 40 ms then on
// - driver button: four discrete wires to the window safety unit
// - passenger button manual up and down go out as message bits
// - rear left and rear right manual up and down go out as message bits
// - window lockout state goes out on a wire and in a message bit
// - mirror positions stored and recalled for two persons
// - key lock edge, ignitions off, knob locked within 3 s: central lock
// - panel or received lock command: lock output for 0.5 s
// - panel or received unlock command: unlock output for 0.5 s
// - smart-key unlock: a transmitter button bit with remote-entry unlock bit
// - smart-key unlock: button bit, a front handle bit and passive unlock bit
package ddm_pkg;
   // register byte offsets
   localparam logic [7:0] DDM_CTRL_OFS = 8'h00;
   localparam logic [7:0] DDM_CMD_OFS = 8'h04;
   localparam logic [7:0] DDM_SMK_OFS = 8'h08;
   localparam logic [7:0] DDM_STAT_OFS = 8'h0c;
   localparam logic [7:0] DDM_MIR0_OFS = 8'h10;
   localparam logic [7:0] DDM_MIR1_OFS = 8'h14;
   // control bits
   localparam int DDM_CTRL_TIMER = 0;
   localparam int DDM_CTRL_FIRST_IGNITION_INPUT = 1;
   localparam int DDM_CTRL_SECOND_IGNITION_INPUT = 2;
   localparam logic [2:0] DDM_CTRL_RST = 3'h0;
   // command bits
   localparam int DDM_CMD_LOCK = 0;
   localparam int DDM_CMD_UNLOCK = 1;
   // smart-key frame bits
   localparam int DDM_SMK_TRANSMITTER_BUTTON_ONE = 0;
   localparam int DDM_SMK_TRANSMITTER_BUTTON_TWO = 1;
   localparam int DDM_SMK_RKE = 2;
   localparam int DDM_SMK_FLH = 3;
   localparam int DDM_SMK_FRH = 4;
   localparam int DDM_SMK_PUNL = 5;
   // timing
   localparam int DDM_CLK_KHZ = 20000;
   localparam int DDM_GAP_MS = 40;
   localparam int DDM_ARM_MS = 3000;
   localparam int DDM_DOOR_MS = 500;
   localparam int DDM_GAP_CYC = DDM_GAP_MS * DDM_CLK_KHZ;
   localparam int DDM_ARM_CYC = DDM_ARM_MS * DDM_CLK_KHZ;
   localparam int DDM_DOOR_CYC = DDM_DOOR_MS * DDM_CLK_KHZ;
   localparam int DDM_CW = 26;
   localparam int DDM_PW = 16;

   typedef enum logic [2:0] {
      DDM_ST_IDLE = 3'b000,
      DDM_ST_MUP = 3'b001,
      DDM_ST_MDN = 3'b010,
      DDM_ST_AUP = 3'b011,
      DDM_ST_ADN = 3'b100
   } ddm_win_type;

   typedef struct packed {
      logic drv_man_up;
      logic drv_man_dn;
      logic drv_auto_up;
      logic drv_auto_dn;
      logic pas_up;
      logic pas_dn;
      logic rl_up;
      logic rl_dn;
      logic rr_up;
      logic rr_dn;
      logic lockout;
      logic second_ignition_input;
      logic key_lock;
      logic knob_locked;
      logic panel_lock;
      logic panel_unlock;
      logic mem_store;
      logic mem_slot;
      logic mem_recall;
      logic [DDM_PW-1:0] mirror_pos;
   } ddm_pins_type;

   localparam ddm_pins_type DDM_PINS_RST = '0;
endpackage

// ---- src/ddm_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddm_top
   import ddm_pkg::*;
#(
   parameter int GAP_CYC = DDM_GAP_CYC,
   parameter int ARM_CYC = DDM_ARM_CYC,
   parameter int DOOR_CYC = DDM_DOOR_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // switch and ignition pins
   input wire ddm_pins_type pins,
   // window motor control
   output logic win_up,
   output logic win_dn,
   output logic win_en,
   // wires to the window safety unit
   output logic safety_man_up,
   output logic safety_man_dn,
   output logic safety_auto_up,
   output logic safety_auto_dn,
   output logic safety_lockout,
   // door lock actuators
   output logic lock_out,
   output logic unlock_out,
   // mirror recall target
   output logic [DDM_PW-1:0] mirror_target
);

   ddm_pins_type pin_s1_q;
   ddm_pins_type pin_q;
   ddm_pins_type prev_q;
   logic [2:0] ctrl_q;
   logic [5:0] smk_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_d;
   logic rd_err;
   logic apb_wr;
   logic can_lock;
   logic can_unlock;
   logic smk_wr;
   logic smk_unlock;
   logic gate;
   ddm_win_type st_q;
   ddm_win_type st_d;
   logic [DDM_CW-1:0] gap_q;
   logic [DDM_CW-1:0] gap_d;
   logic win_up_q;
   logic win_dn_q;
   logic win_en_q;
   logic [4:0] safety_q;
   logic key_rise;
   logic ign_off;
   logic [DDM_CW-1:0] arm_q;
   logic key_lock_req;
   logic lock_req;
   logic unlock_req;
   logic [DDM_CW-1:0] lock_cnt_q;
   logic [DDM_CW-1:0] unl_cnt_q;
   logic lock_out_q;
   logic unlock_out_q;
   logic [DDM_PW-1:0] mir_mem [0:1];
   logic [DDM_PW-1:0] mir_tgt_q;

   // two-stage synchroniser for every pin; prev_q feeds edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= DDM_PINS_RST;
         pin_q <= DDM_PINS_RST;
         prev_q <= DDM_PINS_RST;
      end else begin
         pin_s1_q <= pins;
         pin_q <= pin_s1_q;
         prev_q <= pin_q;
      end
   end

   // apb: no wait state; pready and all answers come from flops
   // writes and command pulses act only in the access cycle that carries pready
   assign apb_wr = psel & penable & pready_q & pwrite;
   assign can_lock = apb_wr & (paddr == DDM_CMD_OFS) & pwdata[DDM_CMD_LOCK];
   assign can_unlock = apb_wr & (paddr == DDM_CMD_OFS) & pwdata[DDM_CMD_UNLOCK];
   assign smk_wr = apb_wr & (paddr == DDM_SMK_OFS);

   always_comb begin
      rd_d = 32'h0;
      rd_err = 1'b0;
      case (paddr)
         DDM_CTRL_OFS: rd_d = {29'h0, ctrl_q};
         DDM_CMD_OFS: rd_d = 32'h0;
         DDM_SMK_OFS: rd_d = {26'h0, smk_q};
         DDM_STAT_OFS: begin
            rd_d[0] = pin_q.pas_up;
            rd_d[1] = pin_q.pas_dn;
            rd_d[2] = pin_q.rl_up;
            rd_d[3] = pin_q.rl_dn;
            rd_d[4] = pin_q.rr_up;
            rd_d[5] = pin_q.rr_dn;
            rd_d[6] = pin_q.lockout;
            rd_d[7] = win_up_q;
            rd_d[8] = win_dn_q;
            rd_d[9] = win_en_q;
            rd_d[10] = lock_out_q;
            rd_d[11] = unlock_out_q;
            rd_d[12] = (arm_q != '0);
         end
         DDM_MIR0_OFS: rd_d = {16'h0, mir_mem[0]};
         DDM_MIR1_OFS: rd_d = {16'h0, mir_mem[1]};
         default: rd_err = 1'b1;
      endcase
   end

   // prdata clears when idle so a stale read never looks valid on the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= psel & ~penable;
         pslverr_q <= psel & ~penable & rd_err;
         if (psel & ~penable & ~pwrite) begin
            prdata_q <= rd_d;
         end else if (!psel) begin
            prdata_q <= 32'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= DDM_CTRL_RST;
      end else if (apb_wr && paddr == DDM_CTRL_OFS) begin
         ctrl_q <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smk_q <= 6'h0;
      end else if (smk_wr) begin
         smk_q <= pwdata[5:0];
      end
   end

   // smart-key frame is judged on the write itself, not on the stored copy
   assign smk_unlock = smk_wr & (pwdata[DDM_SMK_TRANSMITTER_BUTTON_ONE] | pwdata[DDM_SMK_TRANSMITTER_BUTTON_TWO]) &
      (pwdata[DDM_SMK_RKE] |
       ((pwdata[DDM_SMK_FLH] | pwdata[DDM_SMK_FRH]) & pwdata[DDM_SMK_PUNL]));

   // window control
   assign gate = ctrl_q[DDM_CTRL_TIMER] | pin_q.second_ignition_input;

   // auto buttons take priority over manual ones when several are pressed
   always_comb begin
      st_d = DDM_ST_IDLE;
      if (!gate) begin
         st_d = DDM_ST_IDLE;
      end else if (pin_q.drv_auto_up) begin
         st_d = DDM_ST_AUP;
      end else if (pin_q.drv_auto_dn) begin
         st_d = DDM_ST_ADN;
      end else if (pin_q.drv_man_up) begin
         st_d = DDM_ST_MUP;
      end else if (pin_q.drv_man_dn) begin
         st_d = DDM_ST_MDN;
      end
   end

   // entering auto from idle or the other direction holds the second output off
   // for the gap; from the matching manual state the motor is already moving
   always_comb begin
      gap_d = '0;
      if (st_d == DDM_ST_AUP && st_q != DDM_ST_AUP && st_q != DDM_ST_MUP) begin
         gap_d = DDM_CW'(GAP_CYC);
      end else if (st_d == DDM_ST_ADN && st_q != DDM_ST_ADN && st_q != DDM_ST_MDN) begin
         gap_d = DDM_CW'(GAP_CYC);
      end else if (st_d == st_q && gap_q != '0) begin
         gap_d = gap_q - 1'b1;
      end
   end

   // gate off forces idle, so a later auto request always starts a fresh gap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= DDM_ST_IDLE;
         gap_q <= '0;
      end else begin
         st_q <= st_d;
         gap_q <= gap_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_up_q <= 1'b0;
         win_dn_q <= 1'b0;
         win_en_q <= 1'b0;
      end else begin
         win_en_q <= gate;
         case (st_d)
            DDM_ST_IDLE: begin
               win_up_q <= 1'b0;
               win_dn_q <= 1'b0;
            end
            DDM_ST_MUP: begin
               win_up_q <= 1'b1;
               win_dn_q <= 1'b0;
            end
            DDM_ST_MDN: begin
               win_up_q <= 1'b0;
               win_dn_q <= 1'b1;
            end
            DDM_ST_AUP: begin
               win_up_q <= 1'b1;
               win_dn_q <= (gap_d == '0);
            end
            DDM_ST_ADN: begin
               win_up_q <= (gap_d == '0);
               win_dn_q <= 1'b1;
            end
            default: begin
               win_up_q <= 1'b0;
               win_dn_q <= 1'b0;
            end
         endcase
      end
   end

   // safety unit wires follow the driver button and lockout switch directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         safety_q <= 5'h0;
      end else begin
         safety_q <= {pin_q.lockout, pin_q.drv_auto_dn, pin_q.drv_auto_up,
            pin_q.drv_man_dn, pin_q.drv_man_up};
      end
   end

   // central lock from the key: the knob may follow within the arm window
   assign key_rise = pin_q.key_lock & ~prev_q.key_lock;
   assign ign_off = ~ctrl_q[DDM_CTRL_FIRST_IGNITION_INPUT] & ~ctrl_q[DDM_CTRL_SECOND_IGNITION_INPUT] & ~pin_q.second_ignition_input;
   assign key_lock_req = ign_off & pin_q.knob_locked &
      (key_rise | (arm_q != '0));

   // ignition on or a locked knob ends arming, so one key edge locks once only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_q <= '0;
      end else if (key_rise && ign_off && !pin_q.knob_locked) begin
         arm_q <= DDM_CW'(ARM_CYC);
      end else if (!ign_off || pin_q.knob_locked) begin
         arm_q <= '0;
      end else if (arm_q != '0) begin
         arm_q <= arm_q - 1'b1;
      end
   end

   assign lock_req = key_lock_req | can_lock |
      (pin_q.panel_lock & ~prev_q.panel_lock);
   assign unlock_req = can_unlock | smk_unlock |
      (pin_q.panel_unlock & ~prev_q.panel_unlock);

   // unlock wins a tie and cuts a running lock: never fight the actuator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_cnt_q <= '0;
         unl_cnt_q <= '0;
      end else if (unlock_req) begin
         unl_cnt_q <= DDM_CW'(DOOR_CYC);
         lock_cnt_q <= '0;
      end else if (lock_req) begin
         lock_cnt_q <= DDM_CW'(DOOR_CYC);
         unl_cnt_q <= '0;
      end else begin
         if (lock_cnt_q != '0) begin
            lock_cnt_q <= lock_cnt_q - 1'b1;
         end
         if (unl_cnt_q != '0) begin
            unl_cnt_q <= unl_cnt_q - 1'b1;
         end
      end
   end

   // outputs are masked by the opposite request so a new command never overlaps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_out_q <= 1'b0;
         unlock_out_q <= 1'b0;
      end else begin
         lock_out_q <= (lock_cnt_q != '0) & ~unlock_req;
         unlock_out_q <= (unl_cnt_q != '0) & ~lock_req | unlock_req;
      end
   end

   // mirror memory, one slot per person
   // store and recall act on rising edges so a held switch never rewrites a slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mir_mem[0] <= '0;
         mir_mem[1] <= '0;
      end else if (pin_q.mem_store && !prev_q.mem_store) begin
         mir_mem[pin_q.mem_slot] <= pin_q.mirror_pos;
      end
   end

   // the target holds until the next recall; the mirror drive owns the approach
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mir_tgt_q <= '0;
      end else if (pin_q.mem_recall && !prev_q.mem_recall) begin
         mir_tgt_q <= mir_mem[pin_q.mem_slot];
      end
   end

   // every output below is a plain copy of a flop, no logic after the register
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign win_up = win_up_q;
   assign win_dn = win_dn_q;
   assign win_en = win_en_q;
   assign safety_man_up = safety_q[0];
   assign safety_man_dn = safety_q[1];
   assign safety_auto_up = safety_q[2];
   assign safety_auto_dn = safety_q[3];
   assign safety_lockout = safety_q[4];
   assign lock_out = lock_out_q;
   assign unlock_out = unlock_out_q;
   assign mirror_target = mir_tgt_q;

endmodule
`default_nettype wire

// ---- test/ddm_top_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddm_top_chk
   import ddm_pkg::*;
#(
   parameter int GAP_CYC = 20,
   parameter int DOOR_CYC = 50
) (
   // bus
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // pins and outputs
   input wire ddm_pins_type pins,
   input wire logic win_up, win_dn, win_en, lock_out, unlock_out,
   input wire logic safety_man_up, safety_man_dn, safety_auto_up, safety_auto_dn,
   input wire logic safety_lockout
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic tmr_q;
   logic [2:0] up_q;
   // auto buttons one cycle back: a new auto request restarts the gap count
   logic [1:0] au_q;
   int lk_q, ul_q, gp_q;
   wire logic gate = tmr_q | pins.second_ignition_input;
   wire logic mup = gate & pins.drv_man_up &
      ~|{pins.drv_man_dn, pins.drv_auto_up, pins.drv_auto_dn};
   // shadow of the timer bit, taken only on a completed mapped write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_q <= 1'b0;
      end else if (psel && penable && pready && pwrite && !pslverr && paddr == DDM_CTRL_OFS) begin
         tmr_q <= pwdata[DDM_CTRL_TIMER];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_q <= 3'h0;
         au_q <= 2'h0;
         lk_q <= 0;
         ul_q <= 0;
         gp_q <= 0;
      end else begin
         up_q <= (up_q == 3'h4) ? up_q : up_q + 3'h1;
         lk_q <= lock_out ? lk_q + 1 : 0;
         ul_q <= unlock_out ? ul_q + 1 : 0;
         au_q <= {pins.drv_auto_up, pins.drv_auto_dn};
         gp_q <= ((win_up ^ win_dn) && (pins.drv_auto_up || pins.drv_auto_dn) &&
            ({pins.drv_auto_up, pins.drv_auto_dn} == au_q)) ? gp_q + 1 : 0;
      end
   end
   a_apb_ready: assert property (psel && !penable |=> pready) else $error("no ready");
   a_gate_off: assert property ((!tmr_q && !pins.second_ignition_input)[*5] |-> !win_en && !win_up && !win_dn)
      else $error("outputs on with gate off");
   a_gate_on: assert property ((up_q == 3'h4 && gate)[*5] |-> win_en)
      else $error("enable off with gate on");
   a_man_up: assert property (mup[*5] |-> win_up && !win_dn)
      else $error("manual up wrong");
   a_gap_len: assert property (gp_q <= GAP_CYC + 4) else $error("gap too long");
   a_lock_len: assert property (lk_q <= DOOR_CYC + 1) else $error("lock too long");
   a_unl_len: assert property (ul_q <= DOOR_CYC + 1) else $error("unlock too long");
   a_door_excl: assert property (!(lock_out && unlock_out)) else $error("both door");
   a_drv_wire: assert property (up_q == 3'h4 |->
      {safety_man_up, safety_man_dn, safety_auto_up, safety_auto_dn} ==
      $past({pins.drv_man_up, pins.drv_man_dn, pins.drv_auto_up, pins.drv_auto_dn}, 3))
      else $error("driver wires wrong");
   a_lockout_wire: assert property (up_q == 3'h4 |-> safety_lockout == $past(pins.lockout, 3))
      else $error("lockout wire wrong");
   c_lock: cover property ($rose(lock_out));
   c_unlock: cover property ($rose(unlock_out));
   c_gap: cover property (gp_q == GAP_CYC);
endmodule
`default_nettype wire

// ---- test/ddm_sw_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddm_sw_model
   import ddm_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // wanted switch state and smart-key frame choice
   input wire ddm_pins_type want,
   input wire logic [1:0] sk_sel,
   // to the door module
   output var ddm_pins_type pins,
   output logic [31:0] frame
);
   localparam logic [31:0] B = 32'h1;
   // contacts move just after an edge, never mid-cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= DDM_PINS_RST;
      end else begin
         pins <= want;
      end
   end
   // two valid unlock frames, then one that lacks a qualifier and one that lacks a button bit
   always_comb begin
      case (sk_sel)
         2'h0: frame = (B << DDM_SMK_TRANSMITTER_BUTTON_ONE) | (B << DDM_SMK_RKE);
         2'h1: frame = (B << DDM_SMK_TRANSMITTER_BUTTON_TWO) | (B << DDM_SMK_FRH) | (B << DDM_SMK_PUNL);
         2'h2: frame = (B << DDM_SMK_TRANSMITTER_BUTTON_ONE) | (B << DDM_SMK_FLH);
         default: frame = B << DDM_SMK_RKE;
      endcase
   end
endmodule
`default_nettype wire

// ---- test/ddm_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddm_top_tb_top
   import ddm_pkg::*;
;
   localparam int GAP = 20;
   localparam int ARM = 200;
   localparam int DOOR = 50;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, f;
   logic win_up, win_dn, win_en, lock_out, unlock_out, safety_lockout;
   logic safety_man_up, safety_man_dn, safety_auto_up, safety_auto_dn;
   logic [15:0] mirror_target;
   logic [1:0] sk, g;
   logic [4:0] p;
   ddm_pins_type w, pins;
   int err_count, check_count;

   ddm_top #(.GAP_CYC(GAP), .ARM_CYC(ARM), .DOOR_CYC(DOOR)) DUT (.*);
   ddm_sw_model u_sw (.pclk, .presetn, .want(w), .sk_sel(sk), .pins, .frame(f));

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic btn(input int d, input logic m, input logic a);
      if (d == 0) begin
         w.drv_man_up <= m;
         w.drv_auto_up <= a;
      end else begin
         w.drv_man_dn <= m;
         w.drv_auto_dn <= a;
      end
   endtask
   task automatic clr;
      btn(0, 0, 0);
      btn(1, 0, 0);
      cyc(6);
   endtask
   // waits for a door pulse, then measures its length
   task automatic door(input logic [1:0] e);
      int n;
      logic [1:0] s;
      n = 0;
      for (int i = 0; i < 20 && !(lock_out | unlock_out); i++) @(posedge pclk);
      s = {lock_out, unlock_out};
      while (lock_out | unlock_out) begin
         n++;
         @(posedge pclk);
      end
      chk(s, e);
      if (e != 2'b00) chk(n >= DOOR && n <= DOOR + 1, 1);
   endtask
   task automatic mem(input logic s, input logic r, input logic [15:0] v);
      w.mem_slot <= s;
      w.mirror_pos <= v;
      cyc(2);
      if (r) w.mem_recall <= 1'b1;
      else w.mem_store <= 1'b1;
      cyc(6);
      w.mem_recall <= 1'b0;
      w.mem_store <= 1'b0;
      cyc(6);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      #2000000;
      err_count++;
      summarize;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      w = DDM_PINS_RST;
      sk = 2'h0;
      err_count = 0;
      check_count = 0;
      cyc(6);
      presetn <= 1'b1;
      cyc(1);
      rw(0, DDM_CTRL_OFS, 0);
      chk(rd, {29'h0, DDM_CTRL_RST});
      rw(1, 8'h18, 32'h1);
      chk(se, 1);
      w.drv_man_up <= 1'b1;
      cyc(6);
      chk({win_en, win_up, win_dn}, 3'b000);
      w.second_ignition_input <= 1'b1;
      cyc(6);
      chk({win_en, win_up, win_dn}, 3'b110);
      btn(0, 0, 0);
      btn(1, 1, 0);
      cyc(6);
      chk({win_en, win_up, win_dn}, 3'b101);
      btn(1, 0, 0);
      w.second_ignition_input <= 1'b0;
      rw(1, DDM_CTRL_OFS, 32'h1 << DDM_CTRL_TIMER);
      cyc(6);
      chk({win_en, win_up, win_dn}, 3'b100);
      $display("gate test done");
      for (int d = 0; d < 2; d++) begin
         g = d ? 2'b01 : 2'b10;
         clr;
         btn(d, 0, 1);
         cyc(6);
         chk({win_up, win_dn}, g);
         cyc(GAP - 4);
         chk({win_up, win_dn}, g);
         cyc(6);
         chk({win_up, win_dn}, 2'b11);
         clr;
         btn(1 - d, 1, 0);
         cyc(6);
         btn(d, 0, 1);
         cyc(6);
         chk({win_up, win_dn}, g);
         clr;
         btn(1 - d, 0, 1);
         cyc(GAP + 8);
         btn(1 - d, 0, 0);
         btn(d, 0, 1);
         cyc(6);
         chk({win_up, win_dn}, g);
         clr;
         btn(d, 1, 0);
         cyc(6);
         btn(d, 1, 1);
         cyc(6);
         chk({win_up, win_dn}, 2'b11);
      end
      clr;
      $display("auto test done");
      for (int i = 0; i < 2; i++) begin
         p = i ? 5'h0a : 5'h15;
         {w.drv_man_up, w.drv_man_dn, w.drv_auto_up, w.drv_auto_dn, w.lockout} <= p;
         cyc(6);
         chk({safety_man_up, safety_man_dn, safety_auto_up, safety_auto_dn, safety_lockout}, p);
         rw(0, DDM_STAT_OFS, 0);
         chk(rd[6], p[0]);
      end
      clr;
      for (int i = 0; i < 6; i++) begin
         {w.rr_dn, w.rr_up, w.rl_dn, w.rl_up, w.pas_dn, w.pas_up} <= 6'h1 << i;
         cyc(6);
         rw(0, DDM_STAT_OFS, 0);
         chk(rd[5:0], 6'h1 << i);
      end
      $display("wire test done");
      mem(0, 0, 16'h1234);
      mem(1, 0, 16'hbeef);
      mem(0, 1, 16'h0);
      chk(mirror_target, 16'h1234);
      mem(1, 1, 16'h0);
      chk(mirror_target, 16'hbeef);
      rw(0, DDM_MIR1_OFS, 0);
      chk(rd, 32'hbeef);
      $display("mirror test done");
      w.panel_lock <= 1'b1;
      door(2'b10);
      w.panel_lock <= 1'b0;
      w.panel_unlock <= 1'b1;
      door(2'b01);
      w.panel_unlock <= 1'b0;
      rw(1, DDM_CMD_OFS, 32'h1 << DDM_CMD_LOCK);
      door(2'b10);
      rw(1, DDM_CMD_OFS, 32'h1 << DDM_CMD_UNLOCK);
      door(2'b01);
      for (int i = 0; i < 4; i++) begin
         sk <= i[1:0];
         cyc(1);
         rw(1, DDM_SMK_OFS, f);
         door(i < 2 ? 2'b01 : 2'b00);
      end
      $display("command test done");
      w.knob_locked <= 1'b1;
      cyc(6);
      w.key_lock <= 1'b1;
      door(2'b10);
      w.key_lock <= 1'b0;
      w.knob_locked <= 1'b0;
      cyc(6);
      w.key_lock <= 1'b1;
      cyc(20);
      w.knob_locked <= 1'b1;
      door(2'b10);
      w.key_lock <= 1'b0;
      w.knob_locked <= 1'b0;
      cyc(6);
      w.key_lock <= 1'b1;
      cyc(ARM + 20);
      w.knob_locked <= 1'b1;
      door(2'b00);
      w.key_lock <= 1'b0;
      w.second_ignition_input <= 1'b1;
      cyc(6);
      w.key_lock <= 1'b1;
      door(2'b00);
      $display("key test done");
      summarize;
   end
endmodule

bind ddm_top ddm_top_chk #(.GAP_CYC(GAP_CYC), .DOOR_CYC(DOOR_CYC)) u_chk (.*);
`default_nettype wire
